// *** vccc_cfg.svh ***
`ifndef VCCC_CFG_SVH
`define VCCC_CFG_SVH

// Register indices; byte address is four times the index
`define VCCC_IDX_VSCFG   8'h14
`define VCCC_IDX_VSWID   8'h15
`define VCCC_IDX_PRE     8'h16
`define VCCC_IDX_POST    8'h17
`define VCCC_IDX_CCCFG   8'h18
`define VCCC_IDX_CLPLC   8'h19
`define VCCC_IDX_CLDUR   8'h1A
`define VCCC_IDX_CLPOL   8'h1B
`define VCCC_IDX_STAT    8'h28

// Reset values
`define VCCC_RST_VSCFG   8'h18
`define VCCC_RST_VSWID   8'h0A
`define VCCC_RST_PRE     8'h00
`define VCCC_RST_POST    8'h00
`define VCCC_RST_CCCFG   8'h20
`define VCCC_RST_CLPLC   8'h08
`define VCCC_RST_CLDUR   8'h14
`define VCCC_RST_CLPOL   8'h58

// Field positions
`define VCCC_VS_SRC_OVR  7
`define VCCC_VS_SRC_SEL  6
`define VCCC_VS_POL_OVR  5
`define VCCC_VS_POL      4
`define VCCC_VS_OPOL     3
`define VCCC_VS_FILT     2
`define VCCC_VS_DUR_EN   1
`define VCCC_CO_SRC      7
`define VCCC_CO_POL_OVR  6
`define VCCC_CO_POL      5
`define VCCC_CL_SRC      4
`define VCCC_CL_MID_HI   3
`define VCCC_CL_MID_LO   1
`define VCCC_CL_POL_OVR  7
`define VCCC_CL_POL      6

// Lines without a pin edge before auto select drops the pin
`define VCCC_ALIVE_LINES 12'h100

`endif

// *** vccc_pkg.sv ***
package vccc_pkg;

	typedef enum logic [1:0] {
		CL_IDLE,
		CL_WAIT,
		CL_HOLD
	} vccc_clamp_state_type;

endpackage : vccc_pkg

// *** vccc_cfg_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface vccc_cfg_if;
	logic [7:0] vs_cfg;
	logic [7:0] vs_width;
	logic [7:0] pre_lines;
	logic [7:0] post_lines;
	logic [7:0] cc_cfg;
	logic [7:0] cl_start;
	logic [7:0] cl_width;
	logic [7:0] cl_pol_cfg;
	logic [7:0] status;

	modport regs (
		output vs_cfg, vs_width, pre_lines, post_lines,
		output cc_cfg, cl_start, cl_width, cl_pol_cfg,
		input  status
	);
	modport core (
		input  vs_cfg, vs_width, pre_lines, post_lines,
		input  cc_cfg, cl_start, cl_width, cl_pol_cfg,
		output status
	);
endinterface : vccc_cfg_if

`default_nettype wire

// *** vccc_pol_detect.sv ***
`timescale 1ns/1ns
`default_nettype none

// Active level is the rarer one: a sync pulse is short against its period
module vccc_pol_detect #(
	parameter int W = 10
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Observed level and verdict
	input  wire logic level_in,
	output var  logic active_high
);
	logic [W-1:0] bias_ff;
	logic [W-1:0] nxt_bias;
	wire          at_top = &bias_ff;
	wire          at_bot = ~|bias_ff;

	assign nxt_bias = (level_in && !at_top) ? bias_ff + 1'b1 :
	                  (!level_in && !at_bot) ? bias_ff - 1'b1 : bias_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias_ff     <= '0;
			active_high <= 1'b1;
		end else begin
			bias_ff     <= nxt_bias;
			active_high <= ~bias_ff[W-1];
		end
	end
endmodule : vccc_pol_detect

`default_nettype wire

// *** vccc_apb_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "vccc_cfg.svh"

module vccc_apb_regs (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Configuration towards the core
	vccc_cfg_if.regs         cfg
);
	localparam logic [7:0] RST [0:7] = '{`VCCC_RST_VSCFG,
		`VCCC_RST_VSWID, `VCCC_RST_PRE, `VCCC_RST_POST,
		`VCCC_RST_CCCFG, `VCCC_RST_CLPLC, `VCCC_RST_CLDUR,
		`VCCC_RST_CLPOL};

	logic [7:0] regs_ff [0:7];

	wire [7:0] idx      = {2'b00, paddr[7:2]};
	wire [7:0] off      = idx - `VCCC_IDX_VSCFG;
	wire [2:0] sel_idx  = off[2:0];
	wire       aligned  = paddr[1:0] == 2'b00;
	wire       reg_hit  = aligned && (idx >= `VCCC_IDX_VSCFG) &&
	                      (idx <= `VCCC_IDX_CLPOL);
	wire       stat_hit = aligned && (idx == `VCCC_IDX_STAT);
	wire       setup    = psel && !penable;
	wire       wr_en    = psel && penable && pready && pwrite && reg_hit;
	wire [7:0] rd_byte  = reg_hit ? regs_ff[sel_idx] :
	                      stat_hit ? cfg.status : 8'h00;

	// One cycle of setup gives a registered answer in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !reg_hit && !(stat_hit && !pwrite);
			prdata  <= {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) regs_ff[i] <= RST[i];
		end else if (wr_en) begin
			regs_ff[sel_idx] <= pwdata[7:0];
		end
	end

	assign cfg.vs_cfg     = regs_ff[0];
	assign cfg.vs_width   = regs_ff[1];
	assign cfg.pre_lines  = regs_ff[2];
	assign cfg.post_lines = regs_ff[3];
	assign cfg.cc_cfg     = regs_ff[4];
	assign cfg.cl_start   = regs_ff[5];
	assign cfg.cl_width   = regs_ff[6];
	assign cfg.cl_pol_cfg = regs_ff[7];
endmodule : vccc_apb_regs

`default_nettype wire

// *** vccc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "vccc_cfg.svh"

module vccc_top (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Sync, coast and clamp inputs from the video source
	input  wire logic        hsync_in,
	input  wire logic        vsync_in,
	input  wire logic        sep_vsync_in,
	input  wire logic        coast_in,
	input  wire logic        clamp_in,
	// Processed outputs
	output var  logic        vsync_out,
	output var  logic        pll_hold,
	output var  logic        pll_hsync,
	output var  logic        clamp_out,
	output var  logic [2:0]  clamp_midscale
);
	import vccc_pkg::*;

	vccc_cfg_if cfg ();

	vccc_apb_regs u_regs (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.cfg     (cfg.regs)
	);

	// Horizontal sync, normalised to active high
	logic hs_det;
	logic hs_prev_ff;

	vccc_pol_detect #(.W(10)) u_hs_pol (
		.pclk        (pclk),
		.presetn     (presetn),
		.level_in    (hsync_in),
		.active_high (hs_det)
	);

	wire hs_act   = hsync_in ^ ~hs_det;
	wire hs_lead  = hs_act && !hs_prev_ff;
	wire hs_trail = !hs_act && hs_prev_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hs_prev_ff <= 1'b0;
		else          hs_prev_ff <= hs_act;
	end

	// Vertical sync source: auto keeps the pin while it shows edges
	logic        vs_pin_prev_ff;
	logic [11:0] quiet_lines_ff;
	logic [11:0] nxt_quiet_lines;
	logic        vs_det;

	wire vs_ovr      = cfg.vs_cfg[`VCCC_VS_SRC_OVR];
	wire vs_sel      = cfg.vs_cfg[`VCCC_VS_SRC_SEL];
	wire pin_edge    = vsync_in ^ vs_pin_prev_ff;
	wire pin_alive   = quiet_lines_ff < `VCCC_ALIVE_LINES;
	wire vs_use_sep  = vs_ovr ? vs_sel : !pin_alive;
	wire vs_raw      = vs_use_sep ? sep_vsync_in : vsync_in;

	assign nxt_quiet_lines = pin_edge ? 12'h000 :
		(hs_lead && pin_alive) ? quiet_lines_ff + 12'h001 : quiet_lines_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vs_pin_prev_ff <= 1'b0;
			quiet_lines_ff <= `VCCC_ALIVE_LINES;
		end else begin
			vs_pin_prev_ff <= vsync_in;
			quiet_lines_ff <= nxt_quiet_lines;
		end
	end

	vccc_pol_detect #(.W(10)) u_vs_pol (
		.pclk        (pclk),
		.presetn     (presetn),
		.level_in    (vs_raw),
		.active_high (vs_det)
	);

	// Polarity and filtering
	logic vs_filt_ff;
	logic vs_proc_prev_ff;

	wire vs_pol   = cfg.vs_cfg[`VCCC_VS_POL_OVR] ?
	                cfg.vs_cfg[`VCCC_VS_POL] : vs_det;
	wire vs_act   = vs_raw ^ ~vs_pol;
	wire vs_filt  = cfg.vs_cfg[`VCCC_VS_FILT];
	wire vs_proc  = vs_filt ? vs_filt_ff : vs_act;
	wire vs_lead  = vs_proc && !vs_proc_prev_ff;
	wire vs_trail = !vs_proc && vs_proc_prev_ff;

	// Filter samples only at line starts, so edges sit on a line boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)     vs_filt_ff <= 1'b0;
		else if (hs_lead) vs_filt_ff <= vs_act;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) vs_proc_prev_ff <= 1'b0;
		else          vs_proc_prev_ff <= vs_proc;
	end

	// Output width, counted in lines; width 0 gives no pulse
	logic [7:0] vs_len_ff;
	logic [7:0] nxt_vs_len;

	wire dur_en   = cfg.vs_cfg[`VCCC_VS_DUR_EN];
	wire vs_shape = dur_en ? (vs_len_ff != 8'h00) : vs_proc;

	assign nxt_vs_len = vs_lead ? cfg.vs_width :
		(hs_lead && vs_len_ff != 8'h00) ? vs_len_ff - 8'h01 : vs_len_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) vs_len_ff <= 8'h00;
		else          vs_len_ff <= nxt_vs_len;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) vsync_out <= 1'b0;
		else          vsync_out <= vs_shape ^ ~cfg.vs_cfg[`VCCC_VS_OPOL];
	end

	// Line count of the last frame predicts where the next one starts
	logic [11:0] line_cnt_ff;
	logic [11:0] frame_len_ff;
	logic [7:0]  post_cnt_ff;
	logic [11:0] nxt_line_cnt;
	logic [7:0]  nxt_post_cnt;

	wire [12:0] lead_sum = {1'b0, line_cnt_ff} + {5'h00, cfg.pre_lines};
	// The counter sits one below the line count, so a zero lead gives none
	wire pre_win = (frame_len_ff != 12'h000) &&
	               (lead_sum > {1'b0, frame_len_ff});
	wire post_win = post_cnt_ff != 8'h00;
	// Covers the trail cycle, or coast would drop for one pixel there
	wire post_go  = vs_trail && (cfg.post_lines != 8'h00);
	wire int_coast = vs_proc || post_go || pre_win || post_win;

	assign nxt_line_cnt = vs_lead ? 12'h000 :
		(hs_lead && !(&line_cnt_ff)) ? line_cnt_ff + 12'h001 : line_cnt_ff;
	assign nxt_post_cnt = vs_trail ? cfg.post_lines :
		(hs_lead && post_win) ? post_cnt_ff - 8'h01 : post_cnt_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_cnt_ff  <= 12'h000;
			post_cnt_ff  <= 8'h00;
		end else begin
			line_cnt_ff  <= nxt_line_cnt;
			post_cnt_ff  <= nxt_post_cnt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)     frame_len_ff <= 12'h000;
		else if (vs_lead) frame_len_ff <= line_cnt_ff;
	end

	// Coast selection and the PLL hold
	logic co_det;

	vccc_pol_detect #(.W(10)) u_co_pol (
		.pclk        (pclk),
		.presetn     (presetn),
		.level_in    (coast_in),
		.active_high (co_det)
	);

	wire co_src = cfg.cc_cfg[`VCCC_CO_SRC];
	wire co_pol = cfg.cc_cfg[`VCCC_CO_POL_OVR] ?
	              cfg.cc_cfg[`VCCC_CO_POL] : co_det;
	wire co_ext = coast_in ^ ~co_pol;
	wire nxt_coast = co_src ? co_ext : int_coast;

	// Hold and gated sync share one cause, so the PLL never sees both
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_hold  <= 1'b0;
			pll_hsync <= 1'b0;
		end else begin
			pll_hold  <= nxt_coast;
			pll_hsync <= hs_act && !nxt_coast;
		end
	end

	// Clamp timing
	vccc_clamp_state_type cl_state_ff;
	vccc_clamp_state_type nxt_cl_state;
	logic [7:0]           cl_cnt_ff;
	logic [7:0]           nxt_cl_cnt;
	logic                 cl_det;

	vccc_pol_detect #(.W(10)) u_cl_pol (
		.pclk        (pclk),
		.presetn     (presetn),
		.level_in    (clamp_in),
		.active_high (cl_det)
	);

	wire cl_src = cfg.cc_cfg[`VCCC_CL_SRC];
	wire cl_pol = cfg.cl_pol_cfg[`VCCC_CL_POL_OVR] ?
	              cfg.cl_pol_cfg[`VCCC_CL_POL] : cl_det;
	wire cl_ext = clamp_in ^ ~cl_pol;
	wire cl_last = cl_cnt_ff <= 8'h01;

	always_comb begin
		nxt_cl_state = cl_state_ff;
		nxt_cl_cnt   = cl_cnt_ff;
		case (cl_state_ff)
			CL_IDLE: begin
				if (hs_trail && !cl_src) begin
					nxt_cl_state = CL_WAIT;
					nxt_cl_cnt   = cfg.cl_start;
				end
			end
			CL_WAIT: begin
				if (cl_last) begin
					nxt_cl_state = CL_HOLD;
					nxt_cl_cnt   = cfg.cl_width;
				end else begin
					nxt_cl_cnt = cl_cnt_ff - 8'h01;
				end
			end
			CL_HOLD: begin
				if (cl_last) nxt_cl_state = CL_IDLE;
				else         nxt_cl_cnt   = cl_cnt_ff - 8'h01;
			end
			default: nxt_cl_state = CL_IDLE;
		endcase
		if (cl_src) nxt_cl_state = CL_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cl_state_ff <= CL_IDLE;
			cl_cnt_ff   <= 8'h00;
		end else begin
			cl_state_ff <= nxt_cl_state;
			cl_cnt_ff   <= nxt_cl_cnt;
		end
	end

	wire nxt_clamp = cl_src ? cl_ext : (nxt_cl_state == CL_HOLD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clamp_out      <= 1'b0;
			clamp_midscale <= 3'h0;
		end else begin
			clamp_out      <= nxt_clamp;
			clamp_midscale <= cfg.cc_cfg[`VCCC_CL_MID_HI:`VCCC_CL_MID_LO];
		end
	end

	assign cfg.status = {2'b00, cl_pol, co_pol, vs_use_sep,
	                     clamp_out, pll_hold, vs_pol};

	// Checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence cl_arm_s;
		cl_state_ff == CL_IDLE && hs_trail && !cl_src;
	endsequence
	sequence cl_wait_end_s;
		cl_state_ff == CL_WAIT && cl_last && !cl_src;
	endsequence
	sequence cl_hold_end_s;
		cl_state_ff == CL_HOLD && cl_last && !cl_src;
	endsequence

	vs_src_user_a: assert property (
		vs_ovr |-> vs_use_sep == vs_sel
	) else $error("user source select not honoured");

	vs_src_sep_a: assert property (
		(vs_ovr && vs_sel) |-> vs_raw == sep_vsync_in
	) else $error("separator sync not selected");

	vs_user_pol_a: assert property (
		(cfg.vs_cfg[`VCCC_VS_POL_OVR] && !vs_filt && !dur_en) |=>
		vsync_out == $past(vs_raw ^ cfg.vs_cfg[`VCCC_VS_POL]
		                          ^ cfg.vs_cfg[`VCCC_VS_OPOL])
	) else $error("vertical sync polarity path wrong");

	vs_filter_hold_a: assert property (
		(vs_filt && !hs_lead ##1 vs_filt) |-> $stable(vs_proc)
	) else $error("filtered sync moved between lines");

	vs_width_a: assert property (
		(dur_en && vs_lead && cfg.vs_width != 8'h00) ##1 dur_en |=>
		vsync_out == $past(cfg.vs_cfg[`VCCC_VS_OPOL])
	) else $error("vertical sync width pulse missing");

	coast_lead_a: assert property (
		(!co_src && pre_win) |=> pll_hold
	) else $error("precoast window not applied");

	coast_trail_a: assert property (
		(!co_src && vs_trail && cfg.post_lines != 8'h00) |=> pll_hold[*2]
	) else $error("postcoast extension not applied");

	coast_ext_a: assert property (
		co_src |=> pll_hold == $past(co_ext)
	) else $error("external coast not followed");

	pll_gate_a: assert property (
		pll_hold |-> !pll_hsync
	) else $error("sync reached PLL during coast");

	clamp_arm_a: assert property (
		cl_arm_s |=> cl_state_ff == CL_WAIT && cl_cnt_ff == $past(cfg.cl_start)
	) else $error("clamp placement not loaded");

	clamp_start_a: assert property (
		cl_wait_end_s |=> clamp_out && cl_cnt_ff == $past(cfg.cl_width)
	) else $error("clamp did not start on time");

	clamp_end_a: assert property (
		cl_hold_end_s |=> !clamp_out && cl_state_ff == CL_IDLE
	) else $error("clamp did not end on time");

	clamp_ext_a: assert property (
		cl_src |=> clamp_out == $past(cl_ext) && cl_state_ff == CL_IDLE
	) else $error("external clamp not followed");

	clamp_mid_a: assert property (
		$changed(cfg.cc_cfg) |=>
		clamp_midscale == $past(cfg.cc_cfg[`VCCC_CL_MID_HI:`VCCC_CL_MID_LO])
	) else $error("midscale select not applied");

endmodule : vccc_top

`default_nettype wire

// *** vccc_video_src.sv ***
`timescale 1ns/1ns
`default_nettype none

// Steady frame source: syncs change just after pclk, one line per LINE clocks
module vccc_video_src #(
	parameter int LINE  = 64,
	parameter int HS_W  = 6,
	parameter int LINES = 10,
	parameter int VS_L  = 2
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Frame shape
	input  wire logic vs_act_hi,
	input  wire logic on_sep,
	// Sync outputs
	output var  logic hsync_n,
	output var  logic vsync_pin,
	output var  logic vsync_sep
);
	int   pix_ff;
	int   line_ff;
	logic vs_on;

	assign vs_on = line_ff < VS_L;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_ff  <= 0;
			line_ff <= 0;
		end else begin
			pix_ff <= (pix_ff == LINE - 1) ? 0 : pix_ff + 1;
			if (pix_ff == LINE - 1)
				line_ff <= (line_ff == LINES - 1) ? 0 : line_ff + 1;
		end
	end

	// A source never floats its syncs; the unused one rests at its idle level
	always_comb begin
		hsync_n   = !(pix_ff < HS_W);
		vsync_pin = (vs_on && !on_sep) ? vs_act_hi : !vs_act_hi;
		vsync_sep = (vs_on && on_sep) ? vs_act_hi : !vs_act_hi;
	end
endmodule : vccc_video_src

`default_nettype wire

// *** vccc_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module vccc_top_tb;
	import vccc_pkg::*;

	localparam int LINE  = 64;
	localparam int LINES = 10;
	localparam int VS_L  = 2;
	localparam int FRAME = LINE * LINES;
	localparam logic [7:0] RST [8] = '{8'h18, 8'h0A, 8'h00, 8'h00,
		8'h20, 8'h08, 8'h14, 8'h58};

	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, hsync_in, vsync_in, sep_vsync_in;
	logic        coast_in, clamp_in, vsync_out, pll_hold, pll_hsync;
	logic        clamp_out, ppol, psep;
	logic [2:0]  clamp_midscale;
	int          miscompares, compares;

	vccc_top i_vccc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hsync_in(hsync_in), .vsync_in(vsync_in),
		.sep_vsync_in(sep_vsync_in), .coast_in(coast_in),
		.clamp_in(clamp_in), .vsync_out(vsync_out), .pll_hold(pll_hold),
		.pll_hsync(pll_hsync), .clamp_out(clamp_out),
		.clamp_midscale(clamp_midscale));

	vccc_video_src #(.LINE(LINE), .HS_W(6), .LINES(LINES), .VS_L(VS_L))
		i_vccc_video_src (.pclk(pclk), .presetn(presetn),
		.vs_act_hi(ppol), .on_sep(psep), .hsync_n(hsync_in),
		.vsync_pin(vsync_in), .vsync_sep(sep_vsync_in));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic results();
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	task automatic check(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : check

	task automatic apb(input logic wr_en, input logic [7:0] idx,
		input logic [7:0] wd, output logic [7:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr_en;
		paddr   <= {idx[5:0], 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++;
			results();
		end
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		logic       e;
		apb(1'b1, idx, d, r, e);
	endtask : wr

	function automatic int vs_len(logic [7:0] cfg, logic sep, logic pp,
		logic [7:0] w);
		logic sep_used;
		logic hi;
		int   base;
		sep_used = cfg[7] ? cfg[6] : 1'b0;
		hi = cfg[5] ? cfg[4] : pp;
		base = (hi == pp) ? VS_L : LINES - VS_L;
		// A silent source leaves a constant level: never active, or always
		if (sep_used != sep)
			return (hi == pp || cfg[1]) ? 0 : FRAME;
		return (cfg[1] ? int'(w) : base) * LINE;
	endfunction : vs_len

	// Counting over two whole frames makes the result phase independent
	function automatic logic near(int c, int e);
		return (c >= 2 * e - 8) && (c <= 2 * e + 8);
	endfunction : near

	task automatic window(input logic hold, input logic lvl, output int c);
		c = 0;
		repeat (2 * FRAME) begin
			@(posedge pclk);
			if ((hold ? pll_hold : vsync_out) === lvl)
				c++;
			if (pll_hold === 1'b1)
				check(pll_hsync === 1'b0, "hsync in coast");
		end
	endtask : window

	task automatic clamp_run(input int p, input int d);
		int   n, t, w;
		logic prv;
		n = 0;
		prv = 1'b1;
		forever begin
			@(posedge pclk);
			n++;
			if (prv === 1'b0 && hsync_in === 1'b1)
				break;
			prv = hsync_in;
			if (n > 200) begin
				miscompares++;
				results();
			end
		end
		t = 0;
		w = 0;
		for (int k = 1; k < LINE; k++) begin
			@(posedge pclk);
			if (clamp_out === 1'b1) begin
				if (t == 0)
					t = k;
				w++;
			end
		end
		check(t == p + 1, "clamp start");
		check(w == d, "clamp width");
	endtask : clamp_run

	task automatic ext_run(input logic pol);
		logic [1:0] q1, q2;
		wr(8'h19, 8'($urandom_range(1, 255)));
		wr(8'h18, {1'b1, 1'b1, pol, 1'b1, 4'h0});
		wr(8'h1B, {1'b1, pol, 6'h18});
		{coast_in, clamp_in} <= 2'b00;
		q1 = 2'b00;
		q2 = 2'b00;
		repeat (3) @(posedge pclk);
		repeat (40) begin
			@(posedge pclk);
			check(pll_hold === (q2[1] == pol), "ext coast");
			check(clamp_out === (q2[0] == pol), "ext clamp");
			q2 = q1;
			q1 = 2'($urandom);
			{coast_in, clamp_in} <= q1;
		end
	endtask : ext_run

	initial begin
		logic [7:0] v, r, cfg, w;
		logic       e, pp, ps;
		int         c, a, b;
		{presetn, psel, penable, pwrite, coast_in, clamp_in} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		ppol = 1'b1;
		psep = 1'b0;
		miscompares = 0;
		compares = 0;
		void'($urandom(32'hEFCC));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Auto polarity needs about ten lines of sync before it is trusted
		repeat (16 * LINE) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			v = (i == 5 || i == 6) ? 8'($urandom_range(1, 255)) : 8'($urandom);
			apb(1'b0, 8'h14 + 8'(i), 8'h00, r, e);
			check(((r ^ RST[i]) & 8'hFE) === 8'h00, "reset");
			wr(8'h14 + 8'(i), v);
			apb(1'b0, 8'h14 + 8'(i), 8'h00, r, e);
			check(((r ^ v) & ((i % 4 == 0) ? 8'hFE : 8'hFF)) === 8'h00, "rw");
			wr(8'h14 + 8'(i), RST[i]);
		end
		apb(1'b1, 8'h30, 8'h5A, r, e);
		check(e === 1'b1, "unmapped write");
		apb(1'b0, 8'h30, 8'h00, r, e);
		check(e === 1'b1 && r === 8'h00, "unmapped read");
		apb(1'b1, 8'h28, 8'h5A, r, e);
		check(e === 1'b1, "status write");
		apb(1'b0, 8'h28, 8'h00, r, e);
		check(e === 1'b0 && (r & 8'h39) === 8'h31, "status");
		wr(8'h18, 8'hE0);
		clamp_run(8, 20);
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 1 : (i == 7) ? 25 : $urandom_range(1, 25);
			b = (i == 0) ? 1 : (i == 7) ? 30 : $urandom_range(1, 30);
			wr(8'h19, 8'(a));
			wr(8'h1A, 8'(b));
			wr(8'h18, {4'hE, 3'(i), 1'b0});
			clamp_run(a, b);
			check(clamp_midscale === 3'(i), "midscale");
		end
		for (int pol = 0; pol < 2; pol++)
			ext_run(1'(pol));
		for (int i = 0; i < 12; i++) begin
			cfg = (i == 0) ? 8'h18 : 8'($urandom) & 8'hFE;
			ps = cfg[7] & 1'($urandom);
			pp = 1'($urandom);
			w = 8'($urandom_range(0, 7));
			ppol <= pp;
			psep <= ps;
			wr(8'h15, w);
			wr(8'h14, cfg);
			repeat (6 * FRAME) @(posedge pclk);
			window(1'b0, cfg[3], c);
			a = vs_len(cfg, ps, pp, w);
			check(near(c, a), "vsync pulse");
		end
		ppol <= 1'b1;
		psep <= 1'b0;
		wr(8'h14, 8'hB8);
		wr(8'h18, 8'h20);
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 0 : (i == 3) ? 3 : $urandom_range(0, 3);
			b = (i == 0) ? 0 : (i == 3) ? 3 : $urandom_range(0, 3);
			wr(8'h16, 8'(a));
			wr(8'h17, 8'(b));
			repeat (3 * FRAME) @(posedge pclk);
			window(1'b1, 1'b1, c);
			check(near(c, (a + VS_L + b) * LINE), "coast");
		end
		results();
	end
endmodule : vccc_top_tb

`default_nettype wire
